// *** touch_key_pkg.sv ***
// Constants, addresses and state codes of the touch-key host interface.
// Assumes a 20 MHz core clock; shift-register timing is counted on that clock.
package touch_key_pkg;
	localparam int     KEYS             = 24;
	localparam longint CLK_HZ           = 20_000_000;
	localparam longint NS_PER_S         = 1_000_000_000;
	localparam longint US_PER_S         = 1_000_000;
	localparam longint T_SR_CLK_LOW_NS  = 500;
	localparam longint T_SR_CLK_HIGH_US = 125;
	localparam longint T_LATCH_NS       = 500;
	localparam longint T_DATA_SETUP_US  = 75;
	localparam int     SR_CLK_LOW_CYC   = int'((T_SR_CLK_LOW_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int     SR_CLK_HIGH_CYC  = int'((T_SR_CLK_HIGH_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
	localparam int     SR_LATCH_CYC     = int'((T_LATCH_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int     SR_SETUP_CYC     = int'((T_DATA_SETUP_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
	// Clock low phase also carries the data setup, so it takes the longer of both
	localparam int     SR_LOW_PHASE_CYC = (SR_SETUP_CYC > SR_CLK_LOW_CYC) ? SR_SETUP_CYC : SR_CLK_LOW_CYC;
	localparam logic [11:0] SR_LOW_LAST   = 12'(SR_LOW_PHASE_CYC - 1);
	localparam logic [11:0] SR_HIGH_LAST  = 12'(SR_CLK_HIGH_CYC - 1);
	localparam logic [11:0] SR_LATCH_LAST = 12'(SR_LATCH_CYC - 1);
	localparam logic [1:0]  STRAP_WAIT    = 2'h3;

	localparam logic [7:0] ADDR_DETECT_LOW  = 8'h01;
	localparam logic [7:0] ADDR_DETECT_HIGH = 8'h03;
	localparam logic [7:0] ADDR_RAW_LAST    = 8'h7B;
	localparam logic [7:0] ADDR_RECAL       = 8'h7D;
	localparam logic [7:0] ADDR_UNLOCK      = 8'h82;
	localparam logic [7:0] ADDR_SETUP_FIRST = 8'h83;
	localparam logic [7:0] ADDR_SETUP_LAST  = 8'hFD;
	localparam logic [7:0] ADDR_MAX         = 8'hFF;
	localparam logic [7:0] CMD_MAGIC        = 8'h55;
	// Per-key alert enable: bit 7 of the first 24 setup bytes
	localparam logic [7:0] ADDR_ALERT_LAST  = 8'h9A;
	localparam int         ALERT_EN_BIT     = 7;

	localparam logic [6:0] SLA_LOW_HIGH  = 7'h07;
	localparam logic [6:0] SLA_HIGH_LOW  = 7'h11;
	localparam logic [6:0] SLA_HIGH_HIGH = 7'h75;
	localparam logic [3:0] LAST_BIT      = 4'h7;
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	localparam logic [7:0] FIXED_BURST    = 8'h30;
	localparam logic [7:0] FIXED_SLEEP_MS = 8'h7D;

	typedef enum logic [3:0] {
		SR_IDLE  = 4'h1,
		SR_LOW   = 4'h2,
		SR_HIGH  = 4'h4,
		SR_LATCH = 4'h8
	} sr_state_t;

	typedef enum logic [6:0] {
		BUS_IDLE     = 7'h01,
		BUS_ADDR     = 7'h02,
		BUS_ADDR_ACK = 7'h04,
		BUS_WR_BYTE  = 7'h08,
		BUS_WR_ACK   = 7'h10,
		BUS_RD_BYTE  = 7'h20,
		BUS_RD_ACK   = 7'h40
	} bus_state_t;
endpackage

// *** touch_key_host_interface.sv ***
// Two-wire slave, memory map, key-change alert and shift-register output.
// Assumes clk at 20 MHz, a free-running link_clk for bus sampling, and static straps.
// How it works
// - Both selects low: shift-register output mode
// - Select pins choose slave address 7/17/117
// - Serial data, active-low clock, rising edge
// - Latch pulses low after the transfer
// - Bits emitted per key, latch at scan end
// - Bit high when key in detect
// - Unscanned keys shifted after the scan
// - Shift mode uses fixed factory settings
// - Alert stays low in shift mode
// - Slave only, answers matching address only
// - Pointer increments on every read byte, stops at 255
// - Alert rises on any alert-enabled key change
// - Alert clears only reading location 1
// - Per-key alert enable in setups
// - Locations 1-3 return detect status
// - Locations 4-123 return per-key data
// - 0x55 to 125 requests recalibration
// - 0x55 to 130 unlocks setup writes
// - Write order: address, pointer, data, stop
// - Write pointer increments, stops at 255
// - Any read relocks the setups
// - Read: set pointer, stop, start, read
// - Touched reads 1, lowest key bit 0
module touch_key_host_interface (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       link_clk,
	input  wire logic       addr_select_low_pin,
	input  wire logic       addr_select_high_pin,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	output logic            latch_n_out,
	output logic            change_out,
	input  wire logic       core_wr_valid,
	input  wire logic [6:0] core_wr_index,
	input  wire logic [7:0] core_wr_data,
	output logic            core_wr_ready,
	input  wire logic       sr_key_valid,
	input  wire logic       sr_key_detect,
	input  wire logic       sr_scan_end,
	output logic            sr_key_ready,
	output logic            recal_pulse,
	output logic            fixed_settings,
	output logic [7:0]      fixed_burst_len,
	output logic [7:0]      fixed_sleep_ms
);
	typedef struct packed {
		logic                  a0_s1;
		logic                  a0_s2;
		logic                  a1_s1;
		logic                  a1_s2;
		logic [1:0]            wait_cnt;
		logic                  mode_known;
		logic                  sr_mode;
		logic                  req;
		logic                  ack_s1;
		logic                  ack_s2;
		logic                  wr_ready;
		logic [6:0]            wr_index;
		logic [7:0]            wr_data;
		logic                  rc_s1;
		logic                  rc_s2;
		logic                  rc_s3;
		logic                  recal_pulse;
		touch_key_pkg::sr_state_t sr_state;
		logic [11:0]           cnt;
		logic                  sr_data;
		logic                  sr_clk;
		logic                  latch_n;
		logic                  sr_ready;
		logic                  fixed;
		logic [7:0]            burst;
		logic [7:0]            sleep_ms;
	} core_state_t;

	typedef struct packed {
		logic                  scl_s1;
		logic                  scl_s2;
		logic                  scl_s3;
		logic                  sda_s1;
		logic                  sda_s2;
		logic                  sda_s3;
		logic                  a0_s1;
		logic                  a0_s2;
		logic                  a1_s1;
		logic                  a1_s2;
		logic [1:0]            wait_cnt;
		logic                  mode_known;
		logic                  sr_mode;
		logic [6:0]            sla;
		logic                  req_s1;
		logic                  req_s2;
		logic                  req_s3;
		logic                  ack;
		logic                  recal;
		touch_key_pkg::bus_state_t state;
		logic [7:0]            shreg;
		logic [3:0]            bitcnt;
		logic [7:0]            ptr;
		logic                  first;
		logic                  rw;
		logic                  ack_phase;
		logic                  sda_oe;
		logic                  scl_oe;
		logic                  unlock;
		logic                  change;
		logic [23:0]           alert_en;
	} link_state_t;

	core_state_t c_reg;
	core_state_t c_next;
	link_state_t l_reg;
	link_state_t l_next;
	logic [1:0]  lrst_sync;
	logic        link_rstn;
	logic [7:0]  mem [0:255];
	logic [7:0]  rd_byte;
	logic [7:0]  core_addr;
	logic [7:0]  new_byte;
	logic        core_we;
	logic        host_we;
	logic        start_seen;
	logic        stop_seen;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_on;
	logic        load_rd;
	logic        change_set;
	logic        change_clr;

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [7:0] sat_inc(input logic [7:0] a);
		return (a == touch_key_pkg::ADDR_MAX) ? a : 8'(a + 8'h01);
	endfunction

	// Core clock side: straps, shift-register output, handshake sender
	always_comb begin
		c_next = c_reg;
		c_next.a0_s1 = addr_select_low_pin;
		c_next.a0_s2 = c_reg.a0_s1;
		c_next.a1_s1 = addr_select_high_pin;
		c_next.a1_s2 = c_reg.a1_s1;
		if (!c_reg.mode_known) begin
			if (c_reg.wait_cnt == touch_key_pkg::STRAP_WAIT) begin
				c_next.mode_known = 1'b1;
				c_next.sr_mode = ~c_reg.a0_s2 & ~c_reg.a1_s2;
				c_next.sr_clk = ~c_reg.a0_s2 & ~c_reg.a1_s2;
			end else begin
				c_next.wait_cnt = 2'(c_reg.wait_cnt + 2'h1);
			end
		end
		c_next.fixed = c_reg.mode_known & c_reg.sr_mode;
		c_next.ack_s1 = l_reg.ack;
		c_next.ack_s2 = c_reg.ack_s1;
		if (core_wr_valid && c_reg.wr_ready) begin
			c_next.wr_index = core_wr_index;
			c_next.wr_data = core_wr_data;
			c_next.req = ~c_reg.req;
			c_next.wr_ready = 1'b0;
		end else begin
			c_next.wr_ready = (c_reg.ack_s2 == c_reg.req);
		end
		c_next.rc_s1 = l_reg.recal;
		c_next.rc_s2 = c_reg.rc_s1;
		c_next.rc_s3 = c_reg.rc_s2;
		c_next.recal_pulse = c_reg.rc_s2 ^ c_reg.rc_s3;
		unique case (c_reg.sr_state)
			touch_key_pkg::SR_IDLE: begin
				c_next.sr_ready = c_reg.mode_known & c_reg.sr_mode;
				if (c_reg.sr_ready && sr_key_valid) begin
					// Late keys take the same path
					c_next.sr_data = sr_key_detect;
					c_next.sr_clk = 1'b0;
					c_next.cnt = '0;
					c_next.sr_ready = 1'b0;
					c_next.sr_state = touch_key_pkg::SR_LOW;
				end else if (c_reg.sr_ready && sr_scan_end) begin
					c_next.latch_n = 1'b0;
					c_next.cnt = '0;
					c_next.sr_ready = 1'b0;
					c_next.sr_state = touch_key_pkg::SR_LATCH;
				end
			end
			touch_key_pkg::SR_LOW: begin
				if (c_reg.cnt == touch_key_pkg::SR_LOW_LAST) begin
					c_next.sr_clk = 1'b1;
					c_next.cnt = '0;
					c_next.sr_state = touch_key_pkg::SR_HIGH;
				end else begin
					c_next.cnt = 12'(c_reg.cnt + 12'h001);
				end
			end
			touch_key_pkg::SR_HIGH: begin
				if (c_reg.cnt == touch_key_pkg::SR_HIGH_LAST) begin
					c_next.sr_ready = 1'b1;
					c_next.sr_state = touch_key_pkg::SR_IDLE;
				end else begin
					c_next.cnt = 12'(c_reg.cnt + 12'h001);
				end
			end
			touch_key_pkg::SR_LATCH: begin
				if (c_reg.cnt == touch_key_pkg::SR_LATCH_LAST) begin
					c_next.latch_n = 1'b1;
					c_next.sr_ready = 1'b1;
					c_next.sr_state = touch_key_pkg::SR_IDLE;
				end else begin
					c_next.cnt = 12'(c_reg.cnt + 12'h001);
				end
			end
			default: begin
				c_next.sr_state = touch_key_pkg::SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			c_reg <= '{sr_state: touch_key_pkg::SR_IDLE, latch_n: 1'b1,
				burst: touch_key_pkg::FIXED_BURST, sleep_ms: touch_key_pkg::FIXED_SLEEP_MS, default: '0};
		end else begin
			c_reg <= c_next;
		end
	end

	// Release of link reset is aligned to link_clk
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lrst_sync <= 2'h0;
		end else begin
			lrst_sync <= {1'b1, lrst_sync[1]};
		end
	end
	assign link_rstn = lrst_sync[0];

	assign core_addr = {1'b0, c_reg.wr_index};
	assign bus_on = l_reg.mode_known & ~l_reg.sr_mode;
	assign start_seen = l_reg.scl_s2 & l_reg.sda_s3 & ~l_reg.sda_s2;
	assign stop_seen = l_reg.scl_s2 & ~l_reg.sda_s3 & l_reg.sda_s2;
	assign scl_rise = l_reg.scl_s2 & ~l_reg.scl_s3;
	assign scl_fall = ~l_reg.scl_s2 & l_reg.scl_s3;
	assign new_byte = {l_reg.shreg[6:0], l_reg.sda_s2};

	// Status, key data and setups, zero elsewhere
	always_comb begin
		rd_byte = 8'h00;
		if (in_range(l_reg.ptr, touch_key_pkg::ADDR_DETECT_LOW, touch_key_pkg::ADDR_RAW_LAST) ||
				in_range(l_reg.ptr, touch_key_pkg::ADDR_SETUP_FIRST, touch_key_pkg::ADDR_SETUP_LAST)) begin
			rd_byte = mem[l_reg.ptr];
		end
	end

	// Link side: two-wire slave and memory map
	always_comb begin
		l_next = l_reg;
		core_we = 1'b0;
		host_we = 1'b0;
		load_rd = 1'b0;
		change_set = 1'b0;
		change_clr = 1'b0;
		l_next.scl_s1 = scl_in;
		l_next.scl_s2 = l_reg.scl_s1;
		l_next.scl_s3 = l_reg.scl_s2;
		l_next.sda_s1 = sda_in;
		l_next.sda_s2 = l_reg.sda_s1;
		l_next.sda_s3 = l_reg.sda_s2;
		l_next.a0_s1 = addr_select_low_pin;
		l_next.a0_s2 = l_reg.a0_s1;
		l_next.a1_s1 = addr_select_high_pin;
		l_next.a1_s2 = l_reg.a1_s1;
		if (!l_reg.mode_known) begin
			if (l_reg.wait_cnt == touch_key_pkg::STRAP_WAIT) begin
				l_next.mode_known = 1'b1;
				l_next.sr_mode = ~l_reg.a0_s2 & ~l_reg.a1_s2;
				unique case ({l_reg.a1_s2, l_reg.a0_s2})
					2'b01: l_next.sla = touch_key_pkg::SLA_LOW_HIGH;
					2'b10: l_next.sla = touch_key_pkg::SLA_HIGH_LOW;
					2'b11: l_next.sla = touch_key_pkg::SLA_HIGH_HIGH;
					2'b00: l_next.sla = '0;
				endcase
			end else begin
				l_next.wait_cnt = 2'(l_reg.wait_cnt + 2'h1);
			end
		end
		l_next.scl_oe = l_reg.mode_known & l_reg.sr_mode;
		l_next.req_s1 = c_reg.req;
		l_next.req_s2 = l_reg.req_s1;
		l_next.req_s3 = l_reg.req_s2;
		if (l_reg.req_s2 != l_reg.req_s3) begin
			l_next.ack = ~l_reg.ack;
			core_we = in_range(core_addr, touch_key_pkg::ADDR_DETECT_LOW, touch_key_pkg::ADDR_RAW_LAST);
			if (bus_on && in_range(core_addr, touch_key_pkg::ADDR_DETECT_LOW, touch_key_pkg::ADDR_DETECT_HIGH)) begin
				change_set = |((mem[core_addr] ^ c_reg.wr_data) &
					l_reg.alert_en[8 * (core_addr - touch_key_pkg::ADDR_DETECT_LOW) +: 8]);
			end
		end
		if (!bus_on) begin
			l_next.state = touch_key_pkg::BUS_IDLE;
			l_next.sda_oe = l_reg.mode_known & l_reg.sr_mode;
		end else if (start_seen) begin
			l_next.state = touch_key_pkg::BUS_ADDR;
			l_next.bitcnt = '0;
			l_next.sda_oe = 1'b0;
		end else if (stop_seen) begin
			l_next.state = touch_key_pkg::BUS_IDLE;
			l_next.sda_oe = 1'b0;
		end else begin
			unique case (l_reg.state)
				touch_key_pkg::BUS_IDLE: begin
					l_next.sda_oe = 1'b0;
				end
				touch_key_pkg::BUS_ADDR: begin
					if (scl_rise) begin
						l_next.shreg = new_byte;
						l_next.bitcnt = 4'(l_reg.bitcnt + 4'h1);
						if (l_reg.bitcnt == touch_key_pkg::LAST_BIT) begin
							l_next.state = (new_byte[7:1] == l_reg.sla) ? touch_key_pkg::BUS_ADDR_ACK
								: touch_key_pkg::BUS_IDLE;
							l_next.rw = new_byte[0];
							l_next.ack_phase = 1'b0;
						end
					end
				end
				touch_key_pkg::BUS_ADDR_ACK: begin
					if (scl_fall) begin
						if (!l_reg.ack_phase) begin
							l_next.sda_oe = 1'b1;
							l_next.ack_phase = 1'b1;
						end else begin
							l_next.ack_phase = 1'b0;
							l_next.bitcnt = '0;
							l_next.first = 1'b1;
							l_next.sda_oe = 1'b0;
							load_rd = l_reg.rw;
							l_next.state = l_reg.rw ? touch_key_pkg::BUS_RD_BYTE : touch_key_pkg::BUS_WR_BYTE;
						end
					end
				end
				touch_key_pkg::BUS_WR_BYTE: begin
					if (scl_rise) begin
						l_next.shreg = new_byte;
						l_next.bitcnt = 4'(l_reg.bitcnt + 4'h1);
						if (l_reg.bitcnt == touch_key_pkg::LAST_BIT) begin
							l_next.state = touch_key_pkg::BUS_WR_ACK;
							l_next.ack_phase = 1'b0;
							if (l_reg.first) begin
								l_next.first = 1'b0;
								l_next.ptr = new_byte;
							end else begin
								l_next.ptr = sat_inc(l_reg.ptr);
								if (l_reg.ptr == touch_key_pkg::ADDR_RECAL && new_byte == touch_key_pkg::CMD_MAGIC) begin
									l_next.recal = ~l_reg.recal;
								end
								if (l_reg.ptr == touch_key_pkg::ADDR_UNLOCK) begin
									l_next.unlock = (new_byte == touch_key_pkg::CMD_MAGIC);
								end
								host_we = l_reg.unlock & in_range(l_reg.ptr, touch_key_pkg::ADDR_SETUP_FIRST,
									touch_key_pkg::ADDR_SETUP_LAST);
								if (host_we && l_reg.ptr <= touch_key_pkg::ADDR_ALERT_LAST) begin
									l_next.alert_en[5'(l_reg.ptr - touch_key_pkg::ADDR_SETUP_FIRST)] =
										new_byte[touch_key_pkg::ALERT_EN_BIT];
								end
							end
						end
					end
				end
				touch_key_pkg::BUS_WR_ACK: begin
					if (scl_fall) begin
						if (!l_reg.ack_phase) begin
							l_next.sda_oe = 1'b1;
							l_next.ack_phase = 1'b1;
						end else begin
							l_next.sda_oe = 1'b0;
							l_next.ack_phase = 1'b0;
							l_next.bitcnt = '0;
							l_next.state = touch_key_pkg::BUS_WR_BYTE;
						end
					end
				end
				touch_key_pkg::BUS_RD_BYTE: begin
					if (scl_rise) begin
						l_next.bitcnt = 4'(l_reg.bitcnt + 4'h1);
					end else if (scl_fall) begin
						if (l_reg.bitcnt == touch_key_pkg::BYTE_BITS) begin
							l_next.sda_oe = 1'b0;
							l_next.ack_phase = 1'b0;
							l_next.state = touch_key_pkg::BUS_RD_ACK;
						end else begin
							l_next.shreg = {l_reg.shreg[6:0], 1'b0};
							l_next.sda_oe = ~l_reg.shreg[6];
						end
					end
				end
				touch_key_pkg::BUS_RD_ACK: begin
					if (scl_rise) begin
						if (l_reg.sda_s2) begin
							l_next.state = touch_key_pkg::BUS_IDLE;
						end else begin
							l_next.ack_phase = 1'b1;
						end
					end else if (scl_fall && l_reg.ack_phase) begin
						l_next.ack_phase = 1'b0;
						l_next.bitcnt = '0;
						load_rd = 1'b1;
						l_next.state = touch_key_pkg::BUS_RD_BYTE;
					end
				end
				default: begin
					l_next.state = touch_key_pkg::BUS_IDLE;
				end
			endcase
		end
		if (load_rd) begin
			// Bytes are sent MSB first, open drain
			l_next.shreg = rd_byte;
			l_next.sda_oe = ~rd_byte[7];
			l_next.ptr = sat_inc(l_reg.ptr);
			l_next.unlock = 1'b0;
			change_clr = (l_reg.ptr == touch_key_pkg::ADDR_DETECT_LOW);
		end
		// A change arriving with the clearing read is kept
		l_next.change = change_set | (l_reg.change & ~change_clr);
	end

	always_ff @(posedge link_clk or negedge link_rstn) begin
		if (!link_rstn) begin
			l_reg <= '{state: touch_key_pkg::BUS_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1, alert_en: '1, default: '0};
		end else begin
			l_reg <= l_next;
		end
	end

	// Key data has no reset; unwritten locations read undefined
	always_ff @(posedge link_clk) begin
		if (core_we) begin
			mem[core_addr] <= c_reg.wr_data;
		end
		if (host_we) begin
			mem[l_reg.ptr] <= new_byte;
		end
	end

	assign sda_out         = c_reg.sr_data;
	assign scl_out         = c_reg.sr_clk;
	assign sda_oe          = l_reg.sda_oe;
	assign scl_oe          = l_reg.scl_oe;
	assign latch_n_out     = c_reg.latch_n;
	assign change_out      = l_reg.change;
	assign core_wr_ready   = c_reg.wr_ready;
	assign sr_key_ready    = c_reg.sr_ready;
	assign recal_pulse     = c_reg.recal_pulse;
	assign fixed_settings  = c_reg.fixed;
	assign fixed_burst_len = c_reg.burst;
	assign fixed_sleep_ms  = c_reg.sleep_ms;
endmodule // touch_key_host_interface

// *** touch_key_props.sv ***
// Checker for the touch-key interface, core clock domain.
// Bound to the design top; sees its ports only.
module touch_key_props (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       sda_out,
	input wire logic       scl_out,
	input wire logic       latch_n_out,
	input wire logic       change_out,
	input wire logic       sr_key_valid,
	input wire logic       sr_key_detect,
	input wire logic       sr_key_ready,
	input wire logic       recal_pulse,
	input wire logic       fixed_settings,
	input wire logic [7:0] fixed_burst_len,
	input wire logic [7:0] fixed_sleep_ms
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Low time counted here; a repetition that long would stall the tools
	logic [11:0] low_cnt;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= 12'h000;
		end else begin
			low_cnt <= scl_out ? 12'h000 : 12'(low_cnt + 12'h001);
		end
	end
	sequence key_take_s;
		sr_key_valid && sr_key_ready;
	endsequence
	sequence latch_pulse_s;
		!latch_n_out [*8] ##1 !latch_n_out [*2] ##[1:4] latch_n_out;
	endsequence
	a_bus_no_ready: assert property (sr_key_ready |-> fixed_settings)
		else $error("key ready outside shift mode");
	a_key_bit_out: assert property (key_take_s |=> !scl_out && sda_out == $past(sr_key_detect))
		else $error("key bit not driven");
	a_scl_low_hold: assert property ($fell(scl_out) |-> !scl_out [*8])
		else $error("shift clock low too short");
	a_scl_low_len: assert property ($rose(scl_out) && $past(fixed_settings) |->
		low_cnt >= 12'(touch_key_pkg::SR_SETUP_CYC))
		else $error("shift clock low shorter than data setup");
	a_data_stable: assert property (!scl_out && $past(!scl_out) |-> $stable(sda_out))
		else $error("data moved while clock low");
	a_latch_width: assert property ($fell(latch_n_out) |-> latch_pulse_s)
		else $error("latch pulse width wrong");
	a_latch_idle_clk: assert property ($fell(latch_n_out) |-> scl_out && fixed_settings)
		else $error("latch during clock or bus mode");
	a_shift_alert_off: assert property (fixed_settings |-> !change_out)
		else $error("alert active in shift mode");
	a_recal_once: assert property (recal_pulse |=> !recal_pulse)
		else $error("recal pulse too long");
	a_fixed_vals: assert property (fixed_burst_len == 8'h30 && fixed_sleep_ms == 8'h7D)
		else $error("factory values wrong");
endmodule // touch_key_props
bind touch_key_host_interface touch_key_props u_props (.clk, .rstn, .sda_out, .scl_out, .latch_n_out,
	.change_out, .sr_key_valid, .sr_key_detect, .sr_key_ready, .recal_pulse, .fixed_settings,
	.fixed_burst_len, .fixed_sleep_ms);

// *** i2c_host.sv ***
// Two-wire bus host model, open-drain, 100 kHz bits.
// Assumes a pulled-up wire level on sda_w; 1 on a driver means released.
module i2c_host (
	input  wire logic sda_w,
	output logic      sda_drv,
	output logic      scl_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int H = 5000;
	initial begin
		sda_drv = 1'b1;
		scl_drv = 1'b1;
	end
	task automatic start;
		#H sda_drv = 1'b0;
		#H scl_drv = 1'b0;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		#(H / 2) scl_drv = 1'b1;
		#(H / 2) r = sda_w;
		#(H / 2) scl_drv = 1'b0;
		#(H / 2);
	endtask
	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic rx(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		#(H / 2) scl_drv = 1'b1;
		#H sda_drv = 1'b1;
	endtask
endmodule // i2c_host

// *** testbench.sv ***
// Bench: straps, bus map through the host model, then shift mode.
// Assumes design, checker and host model are compiled first.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; $display("BAD %s exp=%h got=%h", nm, ex, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, link_clk, addr_select_low_pin, addr_select_high_pin, sda_out, sda_oe, scl_out, scl_oe;
	logic        latch_n_out, change_out, core_wr_valid, core_wr_ready, sr_key_valid, sr_key_detect, sr_scan_end;
	logic        sr_key_ready, recal_pulse, fixed_settings, host_sda, host_scl, sda_w, scl_w, a;
	logic [6:0]  core_wr_index;
	logic [7:0]  core_wr_data, fixed_burst_len, fixed_sleep_ms, rb, det [1:4], r [$];
	logic [2:0]  sh, sent;
	logic [31:0] seed = 32'h4B54;
	int          errors, n_tests, n_recal, n_latch;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & host_sda;
	assign scl_w = (scl_oe ? scl_out : 1'b1) & host_scl;
	touch_key_host_interface u_dut (.clk, .rstn, .link_clk, .addr_select_low_pin, .addr_select_high_pin,
		.sda_in(sda_w), .sda_out, .sda_oe, .scl_in(scl_w), .scl_out, .scl_oe, .latch_n_out, .change_out,
		.core_wr_valid, .core_wr_index, .core_wr_data, .core_wr_ready, .sr_key_valid, .sr_key_detect,
		.sr_scan_end, .sr_key_ready, .recal_pulse, .fixed_settings, .fixed_burst_len, .fixed_sleep_ms);
	i2c_host u_host (.sda_w(sda_w), .sda_drv(host_sda), .scl_drv(host_scl));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Free-running, phase unrelated to clk
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(negedge clk) if (recal_pulse === 1'b1) n_recal++;
	always @(posedge latch_n_out) n_latch++;
	// Wire levels, so the output enables are checked as well
	always @(posedge scl_w) sh = {sh[1:0], sda_w};
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [6:0] sla_of(input logic [1:0] s);
		return (s == 2'h1) ? 7'h07 : (s == 2'h2) ? 7'h11 : 7'h75;
	endfunction
	task automatic rst(input logic [1:0] s);
		@(negedge clk);
		rstn = 1'b0;
		{addr_select_high_pin, addr_select_low_pin} = s;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (20) @(negedge clk);
	endtask
	// Ready seen at a falling edge means the next rising edge takes the request
	task automatic take(ref logic rdy);
		for (int i = 0; i < 5000 && rdy !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] q [$]);
		u_host.start();
		u_host.tx({7'h07, 1'b0}, a);
		`CHK("ack", 1'b0, a)
		foreach (q[i]) begin
			u_host.tx(q[i], a);
			`CHK("ack", 1'b0, a)
		end
		u_host.stop();
	endtask
	// Pointer set to p, then n bytes read, NACK on the last
	task automatic rd(input logic [7:0] p, input int n);
		r = {};
		wr({p});
		u_host.start();
		u_host.tx({7'h07, 1'b1}, a);
		for (int i = 0; i < n; i++) begin
			u_host.rx(i == n - 1, rb);
			r.push_back(rb);
		end
		u_host.stop();
	endtask
	task automatic cw(input logic [6:0] i, input logic [7:0] d);
		@(negedge clk);
		core_wr_valid = 1'b1;
		core_wr_index = i;
		core_wr_data = d;
		take(core_wr_ready);
		core_wr_valid = 1'b0;
		repeat (30) @(negedge clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Full run is near 95k cycles; small margin keeps the run bounded
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		wrap_up();
	end
	initial begin
		{rstn, core_wr_valid, sr_key_valid, sr_key_detect, sr_scan_end} = 5'h00;
		core_wr_index = 7'h00;
		core_wr_data = 8'h00;
		for (int s = 3; s >= 1; s--) begin
			rst(2'(s));
			u_host.start();
			u_host.tx({sla_of(2'(s)), 1'b0}, a);
			u_host.stop();
			`CHK("sla", 1'b0, a)
		end
		u_host.start();
		u_host.tx({7'h11, 1'b0}, a);
		u_host.stop();
		`CHK("foreign", 1'b1, a)
		for (int i = 1; i <= 4; i++) begin
			seed = lfsr(seed);
			det[i] = seed[7:0];
			cw(7'(i), det[i]);
		end
		rd(8'h01, 4);
		foreach (r[i]) `CHK("map", det[i + 1], r[i])
		`CHK("chg", 1'b0, change_out)
		cw(7'h01, det[1] ^ 8'h02);
		`CHK("chg", 1'b1, change_out)
		rd(8'h02, 1);
		`CHK("chg", 1'b1, change_out)
		rd(8'h01, 1);
		`CHK("chg", 1'b0, change_out)
		// Key 0 alert off, then toggle only key 0
		// Unlock right before setups
		wr({8'h82, 8'h55, 8'h00});
		cw(7'h01, det[1] ^ 8'h03);
		`CHK("mask", 1'b0, change_out)
		rd(8'h83, 1);
		`CHK("setup", 8'h00, r[0])
		wr({8'h83, 8'h80});
		rd(8'h83, 1);
		`CHK("relock", 8'h00, r[0])
		wr({8'h7D, 8'h55});
		repeat (40) @(negedge clk);
		`CHK("recal", 1, n_recal)
		rd(8'h7C, 2);
		`CHK("unmap", 16'h0000, {r[0], r[1]})
		rst(2'h0);
		`CHK("fixed", 17'h1307D, {fixed_settings, fixed_burst_len, fixed_sleep_ms})
		cw(7'h01, ~(det[1] ^ 8'h03));
		`CHK("alert off", 1'b0, change_out)
		n_latch = 0;
		sh = 3'h0;
		// Valid held up between keys
		sr_key_valid = 1'b1;
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			sent[2 - k] = seed[0];
			sr_key_detect = seed[0];
			take(sr_key_ready);
		end
		sr_key_valid = 1'b0;
		sr_scan_end = 1'b1;
		take(sr_key_ready);
		sr_scan_end = 1'b0;
		repeat (20) @(negedge clk);
		`CHK("bits", sent, sh)
		`CHK("latch", 1, n_latch)
		wrap_up();
	end
endmodule // testbench
